// File: design/trace_cfg_consts.svh
// Offsets, field positions, reset values and fixed codes of the trace configuration registers.
// Assumes inclusion by bare name from the counter, the register bank and the testbench.
`ifndef TRACE_CFG_CONSTS_SVH
`define TRACE_CFG_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses, one aligned word each)
`define OFS_EXT_SELECT    12'h000
`define OFS_RELOAD_VALUE  12'h004
`define OFS_CAPABILITY    12'h008
`define OFS_COUNT_VALUE   12'h00C
`define OFS_STATUS        12'h010

// ==========================================================
// Field layouts
`define PICK_WIDTH        8
`define RELOAD_WIDTH      16
`define RELOAD_MSB        15
`define STATUS_STABLE_BIT 0
`define STATUS_ENABLE_BIT 1

// ==========================================================
// Reset values
`define RST_PICK          8'h00
`define RST_RELOAD        16'h0000
`define RST_COUNT         16'h0000
`define RST_WORD          32'h0000_0000

// ==========================================================
// Capability word and its fields
`define CAP_WORD          32'h2800_06E1
`define CAP_COMMIT_BIT    29
`define CAP_COMMIT_VAL    1'h1
`define CAP_TS_MSB        28
`define CAP_TS_LSB        24
`define CAP_TS_VAL        5'h08
`define CAP_BF_MSB        19
`define CAP_BF_LSB        18
`define CAP_EXDATA_BIT    17
`define CAP_QSUP_MSB      16
`define CAP_QSUP_LSB      15
`define CAP_Q_ELEMENT_FILTER_BIT     14
`define CAP_COND_MSB      13
`define CAP_COND_LSB      12
`define CAP_EVENT_MSB     11
`define CAP_EVENT_LSB     10
`define CAP_EVENT_VAL     2'h1
`define CAP_RETSTK_BIT    9
`define CAP_CCI_BIT       7
`define CAP_CONDTRC_BIT   6
`define CAP_BB_BIT        5
`define CAP_DATA_MSB      4
`define CAP_DATA_LSB      3
`define CAP_P0_MSB        2
`define CAP_P0_LSB        1

`endif

// File: design/trace_cfg_pkg.sv
// Types shared by the trace configuration register bank and its counter.
// Assumes the constants header sits beside it in design/.
`default_nettype none

package trace_cfg_pkg;
  typedef logic [7:0]  pick_t;
  typedef logic [15:0] reload_t;
  typedef logic [31:0] word_t;
  typedef logic [11:0] addr_t;
endpackage : trace_cfg_pkg

`default_nettype wire

// File: design/reduced_counter.sv
// Reduced-function counter that takes its reload value on every reload event.
// Assumes reload and decrement events are one-cycle pulses on core_clk.
`default_nettype none

`include "trace_cfg_consts.svh"

module reduced_counter
  import trace_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Events and reload value
  input  wire logic reload_event,
  input  wire logic count_event,
  input  wire reload_t reload_value,
  // Current count
  output reload_t    count_value
);

  // ==========================================================
  // Count update
  // The reload takes priority, so a reload and a decrement in one cycle leave the
  // counter holding the fresh reload value.
  reload_t next_count;
  wire     count_live = (count_value != `RST_COUNT);

  assign next_count = reload_event ? reload_value :
                      (count_event && count_live) ? count_value - 16'h0001 :
                      count_value;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_value <= `RST_COUNT;
    end else begin
      count_value <= next_count;
    end
  end

endmodule : reduced_counter

`default_nettype wire

// File: design/trace_resource_config_regs.sv
// Register bank for the trace unit: external input selector, counter reload
// value, capability word, live count and status.
// Assumes a single-cycle strobe master on core_clk and same-clock status inputs.
//
// Functional notes
// - Selector holds four independent 8-bit input picks.
// - Selector and reload writes ignored while tracing.
// - Reload value sixteen bits, copied on reload.
// - Capability word is read-only and constant.
// - Capability commit mode bit reads one.
// - Timestamp width field reads 0b01000.
// - Branch future, exception data, Q elements absent.
// - Conditional result style field reads zero.
// - Event count field reads 0b01.
// - Return stack support bit reads one.
// - Cycle count, conditional, branch broadcast bits set.
// - Data trace and load/store P0 fields zero.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`default_nettype none

`include "trace_cfg_consts.svh"

module trace_resource_config_regs
  import trace_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Register port
  input  wire addr_t  reg_addr,
  input  wire word_t  wr_data,
  input  wire logic   wr_strobe,
  input  wire logic   rd_strobe,
  output word_t       rd_data,
  // Trace unit state
  input  wire logic   trace_enabled,
  input  wire logic   programming_stable_flag,
  // Counter events
  input  wire logic   reload_event,
  input  wire logic   count_event,
  // Resource selection towards the trace logic
  output pick_t       input_pick_0,
  output pick_t       input_pick_1,
  output pick_t       input_pick_2,
  output pick_t       input_pick_3,
  // Counter state
  output reload_t     reload_value,
  output reload_t     count_value
);

  // ==========================================================
  // Address decode
  wire hit_select = (reg_addr == `OFS_EXT_SELECT);
  wire hit_reload = (reg_addr == `OFS_RELOAD_VALUE);
  wire hit_cap    = (reg_addr == `OFS_CAPABILITY);
  wire hit_count  = (reg_addr == `OFS_COUNT_VALUE);
  wire hit_status = (reg_addr == `OFS_STATUS);

  // Writes to the selector and the reload value are dropped while tracing, so a
  // running trace never sees its resources or reload move underneath it.
  wire write_open    = wr_strobe && !trace_enabled;
  wire write_select  = write_open && hit_select;
  wire write_reload  = write_open && hit_reload;

  // ==========================================================
  // External input selector
  pick_t pick [0:3];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pick
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          pick[gi] <= `RST_PICK;
        end else if (write_select) begin
          pick[gi] <= wr_data[gi*8 +: 8];
        end
      end
    end
  endgenerate

  assign input_pick_0 = pick[0];
  assign input_pick_1 = pick[1];
  assign input_pick_2 = pick[2];
  assign input_pick_3 = pick[3];

  wire word_t select_word = {pick[3], pick[2], pick[1], pick[0]};

  // ==========================================================
  // Counter reload value
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reload_value <= `RST_RELOAD;
    end else if (write_reload) begin
      reload_value <= wr_data[`RELOAD_MSB:0];
    end
  end

  wire word_t reload_word = {16'h0000, reload_value};

  // The counter depends on software having loaded the reload value first.
  reduced_counter u_counter (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .reload_event (reload_event),
    .count_event  (count_event),
    .reload_value (reload_value),
    .count_value  (count_value)
  );

  // ==========================================================
  // Capability word and status
  // The capability word is a constant with no storage behind it, so no write can
  // ever reach it, reserved bits included.
  wire word_t cap_word    = `CAP_WORD;
  wire word_t count_word  = {16'h0000, count_value};
  // Software only trusts the count while the stable flag reads one.
  wire word_t status_word = {30'h0000_0000, trace_enabled, programming_stable_flag};

  // ==========================================================
  // Read path
  // Unmapped offsets read as zero; data stand only in the cycle after the strobe.
  word_t read_mux;
  assign read_mux = hit_select ? select_word :
                    hit_reload ? reload_word :
                    hit_cap    ? cap_word    :
                    hit_count  ? count_word  :
                    hit_status ? status_word :
                    `RST_WORD;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= `RST_WORD;
    end else begin
      rd_data <= rd_strobe ? read_mux : `RST_WORD;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_read_cap;
    rd_strobe && hit_cap;
  endsequence

  sequence s_read_select;
    rd_strobe && hit_select;
  endsequence

  sequence s_read_reload;
    rd_strobe && hit_reload;
  endsequence

  sequence s_blocked_write;
    wr_strobe && trace_enabled && (hit_select || hit_reload);
  endsequence

  sequence s_open_select_write;
    wr_strobe && !trace_enabled && hit_select;
  endsequence

  sequence s_open_reload_write;
    wr_strobe && !trace_enabled && hit_reload;
  endsequence

  a_pick_field_map: assert property (
    s_open_select_write |=>
      input_pick_3 == $past(wr_data[31:24]) && input_pick_2 == $past(wr_data[23:16]) &&
      input_pick_1 == $past(wr_data[15:8])  && input_pick_0 == $past(wr_data[7:0]))
    else $error("Selector fields do not match the written word.");

  a_pick_readback: assert property (
    s_open_select_write ##1 s_read_select |=> rd_data == $past(wr_data, 2))
    else $error("Selector read-back differs from the accepted write.");

  a_locked_while_on: assert property (
    s_blocked_write |=> $stable(select_word) && $stable(reload_value))
    else $error("A write while tracing changed a locked register.");

  a_reload_accepted: assert property (
    s_open_reload_write |=> reload_value == $past(wr_data[15:0]))
    else $error("Reload write while idle was not accepted.");

  a_reload_copy: assert property (
    reload_event |=> count_value == $past(reload_value))
    else $error("Counter did not take the reload value.");

  a_reload_upper_zero: assert property (
    s_read_reload |=> rd_data[31:16] == 16'h0000 && rd_data[15:0] == $past(reload_value))
    else $error("Reload register read-back is wrong.");

  a_cap_write_ignored: assert property (
    (wr_strobe && hit_cap) ##1 s_read_cap |=> rd_data == `CAP_WORD)
    else $error("Capability word changed after a write.");

  a_cap_commit_ts: assert property (
    s_read_cap |=> rd_data[`CAP_COMMIT_BIT] == `CAP_COMMIT_VAL &&
                   rd_data[`CAP_TS_MSB:`CAP_TS_LSB] == `CAP_TS_VAL)
    else $error("Commit mode or timestamp width reads wrong.");

  a_cap_absent_feats: assert property (
    s_read_cap |=> rd_data[`CAP_BF_MSB:`CAP_BF_LSB] == 2'h0 &&
                   !rd_data[`CAP_EXDATA_BIT] &&
                   rd_data[`CAP_QSUP_MSB:`CAP_QSUP_LSB] == 2'h0)
    else $error("An absent feature reads as present.");

  a_cap_cond_events: assert property (
    s_read_cap |=> rd_data[`CAP_COND_MSB:`CAP_COND_LSB] == 2'h0 &&
                   rd_data[`CAP_EVENT_MSB:`CAP_EVENT_LSB] == `CAP_EVENT_VAL)
    else $error("Conditional style or event count reads wrong.");

  a_cap_present_feats: assert property (
    s_read_cap |=> rd_data[`CAP_RETSTK_BIT] && rd_data[`CAP_CCI_BIT] &&
                   rd_data[`CAP_CONDTRC_BIT] && rd_data[`CAP_BB_BIT])
    else $error("A present feature reads as absent.");

  a_cap_data_p0: assert property (
    s_read_cap |=> rd_data[`CAP_DATA_MSB:`CAP_DATA_LSB] == 2'h0 &&
                   rd_data[`CAP_P0_MSB:`CAP_P0_LSB] == 2'h0)
    else $error("Data trace or P0 field reads nonzero.");

  a_cap_reserved: assert property (
    s_read_cap |=> rd_data[31:30] == 2'h0 && rd_data[23:20] == 4'h0 &&
                   !rd_data[`CAP_Q_ELEMENT_FILTER_BIT] && !rd_data[8] && rd_data[0])
    else $error("Capability reserved bits read wrong.");

  a_idle_read_zero: assert property (
    !rd_strobe |=> rd_data == `RST_WORD)
    else $error("Read data stood without a read strobe.");

  // ==========================================================
  // Counter, status and hold checks
  // The counter and status paths are plain logic, yet a slip there silently
  // corrupts trace filtering, so each step of them is watched here as well.
  sequence s_read_count;
    rd_strobe && hit_count;
  endsequence

  sequence s_read_status;
    rd_strobe && hit_status;
  endsequence

  sequence s_read_unmapped;
    rd_strobe && !hit_select && !hit_reload && !hit_cap &&
    !hit_count && !hit_status;
  endsequence

  a_count_readback: assert property (
    s_read_count |=> rd_data == {16'h0000, $past(count_value)})
    else $error("Count read-back differs from the counter.");

  a_status_stable: assert property (
    s_read_status |=> rd_data[`STATUS_STABLE_BIT] == $past(programming_stable_flag))
    else $error("Status stable bit reads wrong.");

  a_status_enable: assert property (
    s_read_status |=> rd_data[`STATUS_ENABLE_BIT] == $past(trace_enabled))
    else $error("Status enable bit reads wrong.");

  a_status_reserved: assert property (
    s_read_status |=> rd_data[31:2] == 30'h0000_0000)
    else $error("Status reserved bits read nonzero.");

  a_unmapped_zero: assert property (
    s_read_unmapped |=> rd_data == `RST_WORD)
    else $error("Unmapped offset read nonzero.");

  a_count_decrement: assert property (
    count_event && !reload_event && count_value != `RST_COUNT |=>
      count_value == $past(count_value) - 16'h0001)
    else $error("Counter did not step down by one.");

  a_count_floor: assert property (
    count_event && !reload_event && count_value == `RST_COUNT |=> count_value == `RST_COUNT)
    else $error("Counter moved below zero.");

  a_count_hold: assert property (
    !count_event && !reload_event |=> $stable(count_value))
    else $error("Counter moved without an event.");

  a_reload_wins: assert property (
    reload_event && count_event |=> count_value == $past(reload_value))
    else $error("Decrement beat the reload.");

  a_select_hold: assert property (
    !write_select |=> $stable(select_word))
    else $error("Selector moved without an accepted write.");

  a_reload_hold: assert property (
    !write_reload |=> $stable(reload_value))
    else $error("Reload value moved without an accepted write.");

  a_locked_select_read: assert property (
    s_blocked_write ##1 s_read_select |=> rd_data == $past(select_word, 2))
    else $error("Selector read-back changed after a refused write.");

  a_locked_reload_read: assert property (
    s_blocked_write ##1 s_read_reload |=> rd_data[15:0] == $past(reload_value, 2))
    else $error("Reload read-back changed after a refused write.");

  a_reload_upper_drop: assert property (
    s_open_reload_write ##1 s_read_reload |=> rd_data[31:16] == 16'h0000)
    else $error("Upper reload bits kept written data.");

  a_reload_low_read: assert property (
    s_open_reload_write ##1 s_read_reload |=>
      rd_data[15:0] == $past(wr_data[`RELOAD_MSB:0], 2))
    else $error("Reload read-back lost the written value.");

  a_cap_whole_word: assert property (
    s_read_cap |=> rd_data == `CAP_WORD)
    else $error("Capability word reads wrong.");

  a_select_read_value: assert property (
    s_read_select |=> rd_data == $past(select_word))
    else $error("Selector read-back differs from the stored fields.");

  a_write_no_data: assert property (
    wr_strobe && !rd_strobe |=> rd_data == `RST_WORD)
    else $error("A write put data on the read port.");

  a_count_after_reload: assert property (
    reload_event ##1 s_read_count |=> rd_data[15:0] == $past(reload_value, 2))
    else $error("Count read after a reload lost the reload value.");

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pick_check
      a_pick_locked: assert property (
        s_blocked_write |=> $stable(pick[gi]))
        else $error("A selector field moved while tracing.");

      a_pick_written: assert property (
        s_open_select_write |=> pick[gi] == $past(wr_data[gi*8 +: 8]))
        else $error("A selector field missed an accepted write.");
    end
  endgenerate

endmodule : trace_resource_config_regs

`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the trace configuration register bank.
// Assumes the package, the constants header and the bank from design/ are compiled first.
`default_nettype none

`include "trace_cfg_consts.svh"

module tb
  import trace_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Signals
  logic    core_clk;
  logic    sys_rst;
  addr_t   reg_addr;
  word_t   wr_data;
  logic    wr_strobe;
  logic    rd_strobe;
  word_t   rd_data;
  logic    trace_enabled;
  logic    programming_stable_flag;
  logic    reload_event;
  logic    count_event;
  pick_t   input_pick_0;
  pick_t   input_pick_1;
  pick_t   input_pick_2;
  pick_t   input_pick_3;
  reload_t reload_value;
  reload_t count_value;
  word_t   got;
  word_t   cap_exp;
  int      miscompares;
  int      compares;
  int      cycles;

  trace_resource_config_regs dut_u (
    .core_clk                (core_clk),
    .sys_rst                 (sys_rst),
    .reg_addr                (reg_addr),
    .wr_data                 (wr_data),
    .wr_strobe               (wr_strobe),
    .rd_strobe               (rd_strobe),
    .rd_data                 (rd_data),
    .trace_enabled           (trace_enabled),
    .programming_stable_flag (programming_stable_flag),
    .reload_event            (reload_event),
    .count_event             (count_event),
    .input_pick_0            (input_pick_0),
    .input_pick_1            (input_pick_1),
    .input_pick_2            (input_pick_2),
    .input_pick_3            (input_pick_3),
    .reload_value            (reload_value),
    .count_value             (count_value)
  );

  // ==========================================================
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // The whole sequence needs well under 200 cycles; the ceiling leaves ample slack.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      $display("wrong value at %0t: run did not finish", $time);
      results();
    end
  end

  // ==========================================================
  // Bus tasks and comparison
  task automatic chk(input word_t g, input word_t e, input string what);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask : chk

  task automatic wr(input addr_t a, input word_t d);
    @(posedge core_clk);
    wr_strobe <= 1'b1;
    reg_addr  <= a;
    wr_data   <= d;
    @(posedge core_clk);
    wr_strobe <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken right there.
  task automatic rd(input addr_t a, output word_t d);
    @(posedge core_clk);
    rd_strobe <= 1'b1;
    reg_addr  <= a;
    @(posedge core_clk);
    rd_strobe <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  task automatic pulse_events(input logic is_reload, input int n);
    @(posedge core_clk);
    reload_event <= is_reload;
    count_event  <= ~is_reload;
    repeat (n) @(posedge core_clk);
    reload_event <= 1'b0;
    count_event  <= 1'b0;
    #1;
  endtask : pulse_events

  task automatic results();
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // ==========================================================
  // Test sequence
  initial begin
    cap_exp = {2'b00, 1'b1, 5'b01000, 4'h0, 2'b00, 1'b0, 2'b00, 1'b0, 2'b00,
               2'b01, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'b00, 2'b00, 1'b1};
    sys_rst = 1'b1;
    reg_addr = 12'h000;
    wr_data = 32'h0000_0000;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    trace_enabled = 1'b0;
    programming_stable_flag = 1'b0;
    reload_event = 1'b0;
    count_event = 1'b0;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;

    rd(`OFS_CAPABILITY, got);
    chk(got, cap_exp, "capability");
    rd(12'h0FC, got);
    chk(got, 32'h0000_0000, "unmapped read");
    $display("test reset and capability done");

    wr(`OFS_EXT_SELECT, 32'hA1B2_C3D4);
    chk({input_pick_3, input_pick_2, input_pick_1, input_pick_0}, 32'hA1B2_C3D4, "picks");
    rd(`OFS_EXT_SELECT, got);
    chk(got, 32'hA1B2_C3D4, "selector read");
    wr(`OFS_RELOAD_VALUE, 32'hFFFF_1234);
    rd(`OFS_RELOAD_VALUE, got);
    chk(got, 32'h0000_1234, "reload read");
    chk({16'h0000, reload_value}, 32'h0000_1234, "reload port");
    $display("test selector and reload done");

    @(posedge core_clk);
    trace_enabled <= 1'b1;
    wr(`OFS_EXT_SELECT, 32'h5555_5555);
    wr(`OFS_RELOAD_VALUE, 32'h0000_7777);
    rd(`OFS_EXT_SELECT, got);
    chk(got, 32'hA1B2_C3D4, "selector locked");
    rd(`OFS_RELOAD_VALUE, got);
    chk(got, 32'h0000_1234, "reload locked");
    @(posedge core_clk);
    trace_enabled <= 1'b0;
    wr(`OFS_CAPABILITY, 32'h0000_0000);
    rd(`OFS_CAPABILITY, got);
    chk(got, cap_exp, "capability after write");
    @(posedge core_clk);
    #1;
    chk(rd_data, 32'h0000_0000, "read data after its cycle");
    $display("test write protection done");

    wr(`OFS_RELOAD_VALUE, 32'h0000_0002);
    pulse_events(1'b1, 1);
    chk({16'h0000, count_value}, 32'h0000_0002, "count after reload");
    pulse_events(1'b0, 3);
    rd(`OFS_COUNT_VALUE, got);
    chk(got, 32'h0000_0000, "count held at zero");
    @(posedge core_clk);
    programming_stable_flag <= 1'b1;
    rd(`OFS_STATUS, got);
    chk(got, 32'h0000_0001, "status");
    $display("test counter and status done");
    results();
  end
endmodule : tb

`default_nettype wire
